// ---- hw/cloi_top.sv ----
`timescale 1ns/1ps

module cloi_fifo #(
    parameter int unsigned WIDTH = 7,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic rdy_q;
    logic push;
    logic pop;

    assign push = ce && in_valid && rdy_q;
    assign pop = ce && out_ready && (cnt_q != '0);
    assign in_ready = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end else if (ce) begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            // Ready is registered so the source sees a flop, not pointer logic.
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule : cloi_fifo

module cloi_rx (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic rxd,
    input wire logic [31:0] div,
    output logic [7:0] data_q,
    output logic valid_q
);
    logic busy_q;
    logic [3:0] idx_q;
    logic [31:0] tmr_q;
    logic [7:0] sh_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            idx_q <= 4'h0;
            tmr_q <= 32'h0;
            sh_q <= 8'h00;
            data_q <= 8'h00;
            valid_q <= 1'b0;
        end else if (ce) begin
            valid_q <= 1'b0;
            if (!busy_q) begin
                if (!rxd) begin
                    busy_q <= 1'b1;
                    idx_q <= 4'h0;
                    tmr_q <= div >> 1;
                end
            end else if (tmr_q != 32'h0) begin
                tmr_q <= tmr_q - 32'h1;
            end else if (idx_q == 4'h0 && rxd) begin
                // A glitch shorter than half a bit is not a start bit.
                busy_q <= 1'b0;
            end else if (idx_q == 4'(cloi_pkg::FRAME_LAST)) begin
                busy_q <= 1'b0;
                data_q <= sh_q;
                valid_q <= rxd;
            end else begin
                if (idx_q != 4'h0) begin
                    sh_q <= {rxd, sh_q[7:1]};
                end
                idx_q <= idx_q + 4'h1;
                tmr_q <= div - 32'h1;
            end
        end
    end
endmodule : cloi_rx

module cloi_top #(
    parameter logic [31:0] DIV_SLOW = 32'(cloi_pkg::BAUD_DIV_SLOW),
    parameter logic [31:0] DIV_FAST = 32'(cloi_pkg::BAUD_DIV_FAST),
    parameter logic [31:0] BREAK_NORM = 32'(cloi_pkg::BREAK_NORM_CYC),
    parameter logic [31:0] BREAK_FAULT = 32'(cloi_pkg::BREAK_FAULT_CYC),
    parameter logic [31:0] PER_FT = 32'(cloi_pkg::CYC_PER_FT),
    parameter logic [31:0] TONE_HALF = 32'(cloi_pkg::TONE_HALF_CYC),
    parameter logic [31:0] INSCRIBE = 32'(cloi_pkg::INSCRIBE_CYC),
    parameter logic [31:0] ANS_MARK = 32'(cloi_pkg::ANS_MARK_HALF),
    parameter logic [31:0] ANS_SPACE = 32'(cloi_pkg::ANS_SPACE_HALF),
    parameter logic [31:0] ORG_MARK = 32'(cloi_pkg::ORG_MARK_HALF),
    parameter logic [31:0] ORG_SPACE = 32'(cloi_pkg::ORG_SPACE_HALF),
    parameter int unsigned DEPTH = cloi_pkg::FIFO_DEPTH
) (
    // Clock, reset and enable.
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    // Characters to send.
    input wire logic [6:0] I_TX_DATA,
    input wire logic I_TX_VALID,
    output logic O_TX_READY,
    // Serial lines and modem options.
    output logic O_TXD_LOCAL,
    input wire logic I_RXD_LOCAL,
    input wire logic I_RXD_MODEM,
    input wire logic I_ORIGINATE,
    input wire logic I_TERM_FLAG,
    output logic O_FSK_TONE,
    output logic O_MODEM_OK,
    output logic O_TERM_FLAG,
    output logic O_RATE_FAST,
    // Received characters.
    output logic [7:0] O_RX_DATA,
    output logic O_RX_VALID,
    output logic [7:0] O_MRX_DATA,
    output logic O_MRX_VALID,
    // Recorder.
    input wire logic I_REC_START,
    input wire logic I_REC_FAULT,
    input wire logic I_CLOUD_VALID,
    input wire logic [13:0] I_CLOUD_HEIGHT,
    output logic O_REC_BREAK,
    output logic O_REC_TONE,
    output logic O_REC_BUSY
);
    logic [6:0] f_data;
    logic f_valid;
    logic f_pop;
    cloi_pkg::cloi_tx_t tx_st_q;
    logic [9:0] tx_sh_q;
    logic [3:0] tx_idx_q;
    logic [31:0] tx_tmr_q;
    logic [31:0] tx_div_q;
    logic fast_q;
    logic [31:0] fsk_cnt_q;
    logic [31:0] fsk_half;
    cloi_pkg::cloi_rec_t rec_st_q;
    logic [31:0] rec_tmr_q;
    logic [31:0] tone_cnt_q;
    logic [31:0] delay_q;
    logic cloud_q;
    logic fault_q;

    assign f_pop = (tx_st_q == cloi_pkg::TX_IDLE);

    cloi_fifo #(.WIDTH(cloi_pkg::ASCII_BITS), .DEPTH(DEPTH)) u_fifo (
        .clk(I_CLK),
        .rst(I_RST),
        .ce(I_CE),
        .in_data(I_TX_DATA),
        .in_valid(I_TX_VALID),
        .in_ready(O_TX_READY),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_pop)
    );

    // One transmitter feeds both lines, so they can never disagree.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            tx_st_q <= cloi_pkg::TX_IDLE;
            tx_sh_q <= 10'h3FF;
            tx_idx_q <= 4'h0;
            tx_tmr_q <= 32'h0;
            tx_div_q <= DIV_SLOW;
            O_TXD_LOCAL <= 1'b1;
        end else if (I_CE) begin
            case (tx_st_q)
                cloi_pkg::TX_IDLE: begin
                    O_TXD_LOCAL <= 1'b1;
                    if (f_valid) begin
                        tx_sh_q <= {1'b1, 1'b1, f_data, 1'b0};
                        tx_idx_q <= 4'h0;
                        // The rate is latched per character so a switch never splits a frame.
                        tx_div_q <= fast_q ? DIV_FAST : DIV_SLOW;
                        tx_tmr_q <= (fast_q ? DIV_FAST : DIV_SLOW) - 32'h1;
                        O_TXD_LOCAL <= 1'b0;
                        tx_st_q <= cloi_pkg::TX_BITS;
                    end
                end
                cloi_pkg::TX_BITS: begin
                    if (tx_tmr_q != 32'h0) begin
                        tx_tmr_q <= tx_tmr_q - 32'h1;
                    end else if (tx_idx_q == 4'(cloi_pkg::FRAME_LAST)) begin
                        tx_st_q <= cloi_pkg::TX_IDLE;
                    end else begin
                        tx_idx_q <= tx_idx_q + 4'h1;
                        O_TXD_LOCAL <= tx_sh_q[tx_idx_q + 4'h1];
                        tx_tmr_q <= tx_div_q - 32'h1;
                    end
                end
                default: tx_st_q <= cloi_pkg::TX_IDLE;
            endcase
        end
    end

    always_comb begin
        if (I_ORIGINATE) begin
            fsk_half = O_TXD_LOCAL ? ORG_MARK : ORG_SPACE;
        end else begin
            fsk_half = O_TXD_LOCAL ? ANS_MARK : ANS_SPACE;
        end
    end

    // The tone follows the shared data line, paralleling the two ports.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            fsk_cnt_q <= 32'h0;
            O_FSK_TONE <= 1'b0;
        end else if (I_CE) begin
            if (fsk_cnt_q == 32'h0) begin
                O_FSK_TONE <= !O_FSK_TONE;
                fsk_cnt_q <= fsk_half - 32'h1;
            end else if (fsk_cnt_q >= fsk_half) begin
                fsk_cnt_q <= fsk_half - 32'h1;
            end else begin
                fsk_cnt_q <= fsk_cnt_q - 32'h1;
            end
        end
    end

    cloi_rx u_rx_local (
        .clk(I_CLK),
        .rst(I_RST),
        .ce(I_CE),
        .rxd(I_RXD_LOCAL),
        .div(fast_q ? DIV_FAST : DIV_SLOW),
        .data_q(O_RX_DATA),
        .valid_q(O_RX_VALID)
    );

    cloi_rx u_rx_modem (
        .clk(I_CLK),
        .rst(I_RST),
        .ce(I_CE),
        .rxd(I_RXD_MODEM),
        .div(DIV_SLOW),
        .data_q(O_MRX_DATA),
        .valid_q(O_MRX_VALID)
    );

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            fast_q <= 1'b0;
            O_RATE_FAST <= 1'b0;
            O_MODEM_OK <= 1'b1;
            O_TERM_FLAG <= 1'b0;
        end else if (I_CE) begin
            if (O_RX_VALID && O_RX_DATA == cloi_pkg::CMD_RATE_FAST) begin
                fast_q <= 1'b1;
            end else if (O_RX_VALID && O_RX_DATA == cloi_pkg::CMD_RATE_SLOW) begin
                fast_q <= 1'b0;
            end
            O_RATE_FAST <= fast_q;
            O_MODEM_OK <= !fast_q;
            O_TERM_FLAG <= I_TERM_FLAG;
        end
    end

    // Recorder: break, then height delay, then inscription tone.
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rec_st_q <= cloi_pkg::REC_IDLE;
            rec_tmr_q <= 32'h0;
            tone_cnt_q <= 32'h0;
            delay_q <= 32'h0;
            cloud_q <= 1'b0;
            fault_q <= 1'b0;
            O_REC_BREAK <= 1'b0;
            O_REC_TONE <= 1'b0;
            O_REC_BUSY <= 1'b0;
        end else if (I_CE) begin
            case (rec_st_q)
                cloi_pkg::REC_IDLE: begin
                    O_REC_TONE <= 1'b0;
                    O_REC_BUSY <= 1'b0;
                    if (I_REC_START) begin
                        fault_q <= I_REC_FAULT;
                        cloud_q <= I_CLOUD_VALID && (I_CLOUD_HEIGHT <= cloi_pkg::HEIGHT_MAX);
                        delay_q <= 32'(I_CLOUD_HEIGHT * PER_FT);
                        rec_tmr_q <= (I_REC_FAULT ? BREAK_FAULT : BREAK_NORM) - 32'h1;
                        O_REC_BREAK <= 1'b1;
                        O_REC_BUSY <= 1'b1;
                        rec_st_q <= cloi_pkg::REC_BREAK;
                    end
                end
                cloi_pkg::REC_BREAK: begin
                    if (rec_tmr_q != 32'h0) begin
                        rec_tmr_q <= rec_tmr_q - 32'h1;
                    end else begin
                        O_REC_BREAK <= 1'b0;
                        rec_tmr_q <= delay_q;
                        rec_st_q <= cloud_q ? cloi_pkg::REC_DELAY : cloi_pkg::REC_IDLE;
                    end
                end
                cloi_pkg::REC_DELAY: begin
                    if (rec_tmr_q != 32'h0) begin
                        rec_tmr_q <= rec_tmr_q - 32'h1;
                    end else begin
                        O_REC_TONE <= 1'b1;
                        tone_cnt_q <= TONE_HALF - 32'h1;
                        rec_tmr_q <= INSCRIBE - 32'h1;
                        rec_st_q <= cloi_pkg::REC_TONE;
                    end
                end
                cloi_pkg::REC_TONE: begin
                    if (tone_cnt_q == 32'h0) begin
                        O_REC_TONE <= !O_REC_TONE;
                        tone_cnt_q <= TONE_HALF - 32'h1;
                    end else begin
                        tone_cnt_q <= tone_cnt_q - 32'h1;
                    end
                    if (rec_tmr_q != 32'h0) begin
                        rec_tmr_q <= rec_tmr_q - 32'h1;
                    end else begin
                        O_REC_TONE <= 1'b0;
                        rec_st_q <= cloi_pkg::REC_IDLE;
                    end
                end
                default: rec_st_q <= cloi_pkg::REC_IDLE;
            endcase
        end
    end

    logic [31:0] brk_len_q;
    always_ff @(posedge I_CLK) begin
        if (I_RST || !O_REC_BREAK) begin
            brk_len_q <= 32'h0;
        end else if (I_CE) begin
            brk_len_q <= brk_len_q + 32'h1;
        end
    end

    a_break_length: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        $fell(O_REC_BREAK) |-> $past(brk_len_q) == (fault_q ? BREAK_FAULT : BREAK_NORM) - 32'h1)
        else $error("Relay break length wrong.");
    a_break_start: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (rec_st_q == cloi_pkg::REC_IDLE && I_REC_START) |=> O_REC_BREAK && O_REC_BUSY)
        else $error("Trigger did not open the relay.");
    a_delay_load: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        ($fell(O_REC_BREAK) && rec_st_q == cloi_pkg::REC_DELAY) |-> rec_tmr_q == delay_q)
        else $error("Delay not started at end of break.");
    a_no_cloud: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        O_REC_TONE |-> (rec_st_q == cloi_pkg::REC_TONE && cloud_q && !O_REC_BREAK))
        else $error("Tone outside the inscription window.");
    a_tone_half: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (rec_st_q == cloi_pkg::REC_TONE && tone_cnt_q != 32'h0 && rec_tmr_q != 32'h0)
        |=> $stable(O_REC_TONE))
        else $error("Inscription tone toggled early.");
    a_start_bit: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (tx_st_q == cloi_pkg::TX_IDLE && f_valid) |=> !O_TXD_LOCAL ##0 tx_tmr_q == tx_div_q - 32'h1)
        else $error("Start bit not sent.");
    a_mark_bit8: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (tx_st_q == cloi_pkg::TX_BITS && tx_idx_q >= 4'h8) |-> O_TXD_LOCAL)
        else $error("Eighth data bit or stop bit not mark.");
    a_rate_cmd: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (O_RX_VALID && O_RX_DATA == cloi_pkg::CMD_RATE_FAST) |=> fast_q ##1 (O_RATE_FAST && !O_MODEM_OK))
        else $error("Rate command not applied.");
    a_fsk_freq: assert property (@(posedge I_CLK) disable iff (I_RST || !I_CE)
        (!$past(I_ORIGINATE) && $changed(O_FSK_TONE))
        |-> fsk_cnt_q == ($past(O_TXD_LOCAL) ? ANS_MARK : ANS_SPACE) - 32'h1)
        else $error("Modem tone does not follow the data line.");
endmodule : cloi_top

// ---- hw/cloi_pkg.sv ----
// Summary of operation
// - Each character is one start bit, eight data bits, no parity, one stop bit.
// - Seven-bit ASCII characters; the eighth data bit is always sent as mark.
// - The modem line carries full-duplex asynchronous data at 300 baud.
// - Answer mode sends mark as 2225 Hz, space as 2025 Hz; originate optional.
// - A normal recorder trigger opens the relay contact for 80 ms.
// - A fault lengthens the relay break to 200 ms.
// - Inscription delay timing starts when the trigger break ends.
// - Delay is linear in height, 3 s at 12000 ft, zero at ground.
// - The inscription tone runs at twice line frequency, normally 120 Hz.
// - The local port is full duplex and carries the same stream as the modem.
// - The local port starts at 300 baud and moves to 1200 on command.
// - The modem path stays valid only at 300 baud.
// - The device drives local transmit data; the far end drives receive data.
package cloi_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD_SLOW = 300;
    localparam int unsigned BAUD_FAST = 1200;
    localparam int unsigned BAUD_DIV_SLOW = CLK_HZ / BAUD_SLOW;
    localparam int unsigned BAUD_DIV_FAST = CLK_HZ / BAUD_FAST;
    localparam int unsigned ANS_MARK_HZ = 2225;
    localparam int unsigned ANS_SPACE_HZ = 2025;
    // Originate tones are the usual low-band pair for this modem family.
    localparam int unsigned ORG_MARK_HZ = 1270;
    localparam int unsigned ORG_SPACE_HZ = 1070;
    localparam int unsigned ANS_MARK_HALF = CLK_HZ / (2 * ANS_MARK_HZ);
    localparam int unsigned ANS_SPACE_HALF = CLK_HZ / (2 * ANS_SPACE_HZ);
    localparam int unsigned ORG_MARK_HALF = CLK_HZ / (2 * ORG_MARK_HZ);
    localparam int unsigned ORG_SPACE_HALF = CLK_HZ / (2 * ORG_SPACE_HZ);
    localparam int unsigned BREAK_NORM_MS = 80;
    localparam int unsigned BREAK_FAULT_MS = 200;
    localparam int unsigned DELAY_MAX_MS = 3000;
    localparam int unsigned HEIGHT_MAX_FT = 12000;
    localparam int unsigned TONE_HZ = 120;
    localparam int unsigned INSCRIBE_MS = 100;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned BREAK_NORM_CYC = BREAK_NORM_MS * CYC_PER_MS;
    localparam int unsigned BREAK_FAULT_CYC = BREAK_FAULT_MS * CYC_PER_MS;
    localparam int unsigned DELAY_MAX_CYC = DELAY_MAX_MS * CYC_PER_MS;
    localparam int unsigned CYC_PER_FT = DELAY_MAX_CYC / HEIGHT_MAX_FT;
    localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
    localparam int unsigned INSCRIBE_CYC = INSCRIBE_MS * CYC_PER_MS;
    localparam int unsigned ASCII_BITS = 7;
    localparam int unsigned FRAME_LAST = 9;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam logic [7:0] CMD_RATE_FAST = 8'h42;
    localparam logic [7:0] CMD_RATE_SLOW = 8'h41;
    localparam logic [13:0] HEIGHT_MAX = 14'h2EE0;
    typedef enum logic [1:0] {
        REC_IDLE = 2'b00,
        REC_BREAK = 2'b01,
        REC_DELAY = 2'b10,
        REC_TONE = 2'b11
    } cloi_rec_t;
    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_BITS = 1'b1
    } cloi_tx_t;
endpackage : cloi_pkg

// ---- verif/cloi_far_model.sv ----
`timescale 1ns/1ps

module cloi_far_model (
    // Clock and decode rate.
    input wire logic i_clk,
    input wire logic [31:0] i_div,
    // Line from the device.
    input wire logic i_txd,
    // Lines into the device.
    output logic o_rxd_local,
    output logic o_rxd_modem,
    output logic o_term_flag
);
    logic [8:0] got[$];
    logic [7:0] sh;

    initial begin
        o_rxd_local = 1'b1;
        o_rxd_modem = 1'b1;
        o_term_flag = 1'b0;
    end

    // Each byte is kept with its stop bit, so a short or missing stop shows up in the comparison.
    initial forever begin
        @(negedge i_clk);
        if (i_txd === 1'b0) begin
            repeat (i_div / 2) @(negedge i_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (i_div) @(negedge i_clk);
                sh[i] = i_txd;
            end
            repeat (i_div) @(negedge i_clk);
            got.push_back({i_txd, sh});
        end
    end

    // The gap lets the far end answer at once or only after a pause; the line rests at mark between frames.
    task automatic send(input logic modem, input logic [7:0] b, input int div, input int gap);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        repeat (gap) @(negedge i_clk);
        for (int i = 0; i < 10; i++) begin
            @(negedge i_clk);
            if (modem) begin
                o_rxd_modem = f[i];
            end else begin
                o_rxd_local = f[i];
            end
            repeat (div - 1) @(negedge i_clk);
        end
    endtask : send

    task automatic set_flag(input logic v);
        @(negedge i_clk);
        o_term_flag = v;
    endtask : set_flag
endmodule : cloi_far_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps

module tb;
    localparam logic [31:0] DS = 32'h10;
    localparam logic [31:0] DF = 32'h8;
    localparam logic [31:0] BN = 32'h14;
    localparam logic [31:0] BF = 32'h32;
    localparam logic [31:0] PF = 32'h1;
    localparam logic [31:0] INS = 32'h28;
    localparam logic [31:0] TH = 32'h4;
    logic I_CLK = 1'b0;
    logic I_RST, I_CE, I_TX_VALID, I_ORIGINATE, I_REC_START, I_REC_FAULT, I_CLOUD_VALID;
    logic I_RXD_LOCAL, I_RXD_MODEM, I_TERM_FLAG;
    logic [6:0] I_TX_DATA;
    logic [13:0] I_CLOUD_HEIGHT;
    logic O_TX_READY, O_TXD_LOCAL, O_FSK_TONE, O_MODEM_OK, O_TERM_FLAG, O_RATE_FAST;
    logic O_RX_VALID, O_MRX_VALID, O_REC_BREAK, O_REC_TONE, O_REC_BUSY;
    logic [7:0] O_RX_DATA, O_MRX_DATA;
    logic [31:0] far_div = DS;
    int fails = 0;
    int n_compared = 0;
    int n_rx = 0;
    int n_mrx = 0;

    always #2 I_CLK = ~I_CLK;
    always @(negedge I_CLK) begin
        if (O_RX_VALID === 1'b1) n_rx++;
        if (O_MRX_VALID === 1'b1) n_mrx++;
    end

    cloi_top #(.DIV_SLOW(DS), .DIV_FAST(DF), .BREAK_NORM(BN), .BREAK_FAULT(BF), .PER_FT(PF), .TONE_HALF(TH),
        .INSCRIBE(INS), .ANS_MARK(32'h5), .ANS_SPACE(32'h7), .ORG_MARK(32'h9), .ORG_SPACE(32'hB)) u_cloi_top (
        .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_TX_DATA(I_TX_DATA), .I_TX_VALID(I_TX_VALID),
        .O_TX_READY(O_TX_READY), .O_TXD_LOCAL(O_TXD_LOCAL), .I_RXD_LOCAL(I_RXD_LOCAL), .I_RXD_MODEM(I_RXD_MODEM),
        .I_ORIGINATE(I_ORIGINATE), .I_TERM_FLAG(I_TERM_FLAG), .O_FSK_TONE(O_FSK_TONE), .O_MODEM_OK(O_MODEM_OK),
        .O_TERM_FLAG(O_TERM_FLAG), .O_RATE_FAST(O_RATE_FAST), .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID),
        .O_MRX_DATA(O_MRX_DATA), .O_MRX_VALID(O_MRX_VALID), .I_REC_START(I_REC_START), .I_REC_FAULT(I_REC_FAULT),
        .I_CLOUD_VALID(I_CLOUD_VALID), .I_CLOUD_HEIGHT(I_CLOUD_HEIGHT), .O_REC_BREAK(O_REC_BREAK),
        .O_REC_TONE(O_REC_TONE), .O_REC_BUSY(O_REC_BUSY));

    cloi_far_model u_cloi_far_model (.i_clk(I_CLK), .i_div(far_div), .i_txd(O_TXD_LOCAL),
        .o_rxd_local(I_RXD_LOCAL), .o_rxd_modem(I_RXD_MODEM), .o_term_flag(I_TERM_FLAG));

    task complete_run;
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task tmo(input string what);
        fails++;
        $display("[ERR] %s expected done seen timeout", what);
        complete_run();
    endtask : tmo

    // Valid stays up between back-to-back characters; tx_idle drops it afterwards.
    task push(input logic [6:0] ch);
        int k;
        @(negedge I_CLK);
        I_TX_VALID = 1'b1;
        I_TX_DATA = ch;
        k = 0;
        while (O_TX_READY !== 1'b1 && k < 20000) begin
            @(negedge I_CLK);
            k++;
        end
        if (k >= 20000) tmo("tx_ready");
    endtask : push

    task tx_idle;
        @(negedge I_CLK);
        I_TX_VALID = 1'b0;
    endtask : tx_idle

    task chk_frames(input logic [6:0] first, input int n);
        int k;
        k = 0;
        while (u_cloi_far_model.got.size() < n && k < 40000) begin
            @(negedge I_CLK);
            k++;
        end
        if (k >= 40000) tmo("frames");
        for (int i = 0; i < n; i++) begin
            chk("frame", 32'({2'b11, 7'(first + i)}), 32'(u_cloi_far_model.got.pop_front()));
        end
    endtask : chk_frames

    task half_per(output int n);
        logic v;
        int k;
        @(negedge I_CLK);
        v = O_FSK_TONE;
        k = 0;
        while (O_FSK_TONE === v && k < 100) begin
            @(negedge I_CLK);
            k++;
        end
        v = O_FSK_TONE;
        n = 0;
        while (O_FSK_TONE === v && n < 100) begin
            @(negedge I_CLK);
            n++;
        end
    endtask : half_per

    task t_tx;
        push(7'h55);
        push(7'h56);
        push(7'h57);
        tx_idle();
        chk_frames(7'h55, 3);
    endtask : t_tx

    task t_fsk;
        int n;
        int k;
        half_per(n);
        chk("mark_ans", 32'h5, n);
        I_ORIGINATE = 1'b1;
        half_per(n);
        half_per(n);
        chk("mark_org", 32'h9, n);
        I_ORIGINATE = 1'b0;
        push(7'h00);
        tx_idle();
        k = 0;
        while (O_TXD_LOCAL !== 1'b0 && k < 100) begin
            @(negedge I_CLK);
            k++;
        end
        if (k >= 100) tmo("txd_low");
        repeat (20) @(negedge I_CLK);
        half_per(n);
        chk("space_ans", 32'h7, n);
        chk_frames(7'h00, 1);
    endtask : t_fsk

    task t_rx;
        fork
            begin
                push(7'h31);
                tx_idle();
            end
            u_cloi_far_model.send(1'b0, 8'hA5, DS, 3);
        join
        repeat (4) @(negedge I_CLK);
        chk("rx_cnt", 32'h1, n_rx);
        chk("rx_data", 32'hA5, O_RX_DATA);
        chk_frames(7'h31, 1);
        u_cloi_far_model.send(1'b1, 8'h3C, DS, 0);
        repeat (4) @(negedge I_CLK);
        chk("mrx_data", 32'h3C, O_MRX_DATA);
        chk("mrx_cnt", 32'h1, n_mrx);
    endtask : t_rx

    task t_rate;
        u_cloi_far_model.send(1'b0, 8'h42, DS, 2);
        repeat (4) @(negedge I_CLK);
        chk("rate_fast", 32'h1, O_RATE_FAST);
        chk("modem_ok", 32'h0, O_MODEM_OK);
        far_div = DF;
        push(7'h4E);
        tx_idle();
        chk_frames(7'h4E, 1);
        u_cloi_far_model.send(1'b1, 8'h66, DS, 0);
        repeat (4) @(negedge I_CLK);
        chk("mrx_slow", 32'h66, O_MRX_DATA);
        u_cloi_far_model.send(1'b0, 8'h41, DF, 0);
        repeat (4) @(negedge I_CLK);
        far_div = DS;
        chk("rate_slow", 32'h0, O_RATE_FAST);
        chk("modem_ok", 32'h1, O_MODEM_OK);
    endtask : t_rate

    task t_fill;
        int cnt;
        cnt = 0;
        @(negedge I_CLK);
        while (O_TX_READY === 1'b1 && cnt < 40) begin
            I_TX_VALID = 1'b1;
            I_TX_DATA = 7'(8'h30 + cnt);
            @(negedge I_CLK);
            cnt++;
        end
        I_TX_VALID = 1'b0;
        chk("fill", 32'h1, 32'(cnt >= 16 && cnt <= 17));
        chk_frames(7'h30, cnt);
        chk("drained", 32'h1, O_TX_READY);
    endtask : t_fill

    // A second start is offered five cycles into the break; it must not alter the sequence.
    task rec_run(input logic flt, input logic cld, input logic [13:0] h, input int brk, input int gap, input int rises);
        int n;
        logic v;
        @(negedge I_CLK);
        I_REC_START = 1'b1;
        I_REC_FAULT = flt;
        I_CLOUD_VALID = cld;
        I_CLOUD_HEIGHT = h;
        @(negedge I_CLK);
        I_REC_START = 1'b0;
        chk("busy", 32'h1, O_REC_BUSY);
        n = 0;
        while (O_REC_BREAK === 1'b1 && n < 300) begin
            @(negedge I_CLK);
            I_REC_START = (n == 4);
            n++;
        end
        chk("break_len", brk, n);
        n = 0;
        while (O_REC_TONE !== 1'b1 && O_REC_BUSY === 1'b1 && n < 20000) begin
            @(negedge I_CLK);
            n++;
        end
        if (gap >= 0) chk("delay", gap, n);
        n = 0;
        v = 1'b0;
        while (O_REC_BUSY === 1'b1 && n < 20000) begin
            if (O_REC_TONE === 1'b1 && v !== 1'b1) rises++;
            v = O_REC_TONE;
            @(negedge I_CLK);
            n++;
        end
        chk("tone_rises", 32'h0, rises);
        chk("tone_idle", 32'h0, O_REC_TONE);
        chk("busy_end", 32'h0, O_REC_BUSY);
    endtask : rec_run

    task t_flag;
        I_CE = 1'b0;
        u_cloi_far_model.set_flag(1'b1);
        repeat (3) @(negedge I_CLK);
        chk("flag_frozen", 32'h0, O_TERM_FLAG);
        I_CE = 1'b1;
        repeat (3) @(negedge I_CLK);
        chk("flag_hi", 32'h1, O_TERM_FLAG);
        u_cloi_far_model.set_flag(1'b0);
        repeat (3) @(negedge I_CLK);
        chk("flag_lo", 32'h0, O_TERM_FLAG);
    endtask : t_flag

    initial begin
        I_RST = 1'b1;
        I_CE = 1'b1;
        I_TX_VALID = 1'b0;
        I_TX_DATA = 7'h00;
        I_ORIGINATE = 1'b0;
        I_REC_START = 1'b0;
        I_REC_FAULT = 1'b0;
        I_CLOUD_VALID = 1'b0;
        I_CLOUD_HEIGHT = 14'h0000;
        repeat (10) @(negedge I_CLK);
        I_RST = 1'b0;
        chk("txd_idle", 32'h1, O_TXD_LOCAL);
        chk("rate_rst", 32'h0, O_RATE_FAST);
        chk("modem_rst", 32'h1, O_MODEM_OK);
        chk("break_rst", 32'h0, O_REC_BREAK);
        t_tx();
        t_fsk();
        t_rx();
        t_rate();
        t_fill();
        t_flag();
        // Expected rises count the tone periods that fit in the inscription window.
        rec_run(1'b0, 1'b1, 14'h001E, BN, 32'h1E * PF + 1, -(INS / (2 * TH)));
        rec_run(1'b0, 1'b1, 14'h0000, BN, 1, -(INS / (2 * TH)));
        rec_run(1'b1, 1'b1, 14'h000A, BF, 32'hA * PF + 1, -(INS / (2 * TH)));
        rec_run(1'b0, 1'b0, 14'h0005, BN, -1, 0);
        rec_run(1'b0, 1'b1, 14'h2EE1, BN, -1, 0);
        complete_run();
    end
endmodule : tb
